// [tec_pkg.sv]
package tec_pkg;

  localparam int TEC_ADDR_W = 8;
  localparam int TEC_NUM = 2;

  // Byte addresses of the register map
  localparam logic [7:0] TEC_A_CTRL1 = 8'h00;
  localparam logic [7:0] TEC_A_TMR1 = 8'h04;
  localparam logic [7:0] TEC_A_CTRL2 = 8'h08;
  localparam logic [7:0] TEC_A_TMR2 = 8'h0C;
  localparam logic [7:0] TEC_A_FLAG = 8'h10;
  localparam logic [7:0] TEC_A_IEN = 8'h14;

  // Control field positions
  localparam int TEC_B_MODE = 6;
  localparam int TEC_B_CSEL = 5;
  localparam int TEC_B_RUN = 4;
  localparam int TEC_B_EDGE = 3;
  localparam int TEC_B_PSC = 0;

  localparam logic [7:0] TEC_CTRL_RST = 8'h08;
  localparam logic [7:0] TEC_CTRL1_MASK = 8'hF8;
  localparam logic [7:0] TEC_CTRL2_MASK = 8'hDF;
  localparam logic [7:0] TEC_PRE_RST = 8'h00;
  localparam logic [7:0] TEC_FULL = 8'hFF;

  localparam logic [1:0] TEC_DIV4_LAST = 2'h3;
  localparam logic [6:0] TEC_PSC_ALL = 7'h7F;

  localparam logic [1:0] TEC_RESP_OKAY = 2'h0;
  localparam logic [1:0] TEC_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    TEC_MODE_NONE = 2'h0,
    TEC_MODE_EVENT = 2'h1,
    TEC_MODE_TIMER = 2'h2,
    TEC_MODE_CAPTURE = 2'h3
  } tec_mode_e;

  typedef enum logic [2:0] {
    TEC_CAP_IDLE = 3'b001,
    TEC_CAP_ARMED = 3'b010,
    TEC_CAP_MEAS = 3'b100
  } tec_cap_e;

  typedef struct packed {
    tec_mode_e mode;
    logic clkSel;
    logic run;
    logic edgeSel;
    logic [2:0] psc;
  } tec_ctrl_s;

endpackage

// [tec_timer_pair.sv]
// Register access over AXI4-Lite and the address map were decided locally.
`timescale 1ns/10ps
module tec_timer_pair
  import tec_pkg::*;
(
  input wire logic sys_clk, // 100 MHz system clock
  input wire logic rst_b, // Async reset, active low
  input wire logic [TEC_NUM-1:0] timerPin, // Timer input pins, first then second
  input wire logic lowFreqCrystal, // Low-frequency crystal clock level
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [TEC_ADDR_W-1:0] s_axi_awaddr, // Write address
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write byte enables
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  output logic [1:0] s_axi_bresp, // Write response
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  input wire logic [TEC_ADDR_W-1:0] s_axi_araddr, // Read address
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic timerIrq, // Enabled overflow request pending
  output logic wakeReq // One-cycle wake pulse on any overflow
);

  logic [TEC_ADDR_W-1:0] awAddr;
  logic [7:0] wByte;
  logic wLane0;
  logic doWrite;
  logic [TEC_NUM-1:0] ovfFlag;
  logic [TEC_NUM-1:0] irqEnable;
  logic [TEC_NUM-1:0] ovf;
  logic [7:0] ctrlRd [TEC_NUM];
  logic [7:0] cntRd [TEC_NUM];
  logic [1:0] div4Cnt;
  logic div4Tick;
  logic [6:0] pscCnt;
  logic [2:0] xtalSync;
  logic xtalFall;
  logic wrFlag;
  logic wrIen;
  logic [7:0] rdByte;
  logic rdHit;

  // Write channel: address and data taken in either order, answered once both are in
  assign doWrite = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_axi_awready <= 1'b1;
      awAddr <= '0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      s_axi_awready <= 1'b0;
      awAddr <= s_axi_awaddr;
    end
    else if (s_axi_bvalid && s_axi_bready)
      s_axi_awready <= 1'b1;
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_axi_wready <= 1'b1;
      wByte <= 8'h00;
      wLane0 <= 1'b0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      s_axi_wready <= 1'b0;
      wByte <= s_axi_wdata[7:0];
      wLane0 <= s_axi_wstrb[0];
    end
    else if (s_axi_bvalid && s_axi_bready)
      s_axi_wready <= 1'b1;
  end

  // Answer only once both halves are in, so a lone address never writes
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= TEC_RESP_OKAY;
    end
    else if (doWrite)
    begin
      s_axi_bvalid <= 1'b1;
      case (awAddr)
        TEC_A_CTRL1, TEC_A_TMR1, TEC_A_CTRL2, TEC_A_TMR2, TEC_A_FLAG, TEC_A_IEN:
          s_axi_bresp <= TEC_RESP_OKAY;
        default:
          s_axi_bresp <= TEC_RESP_SLVERR;
      endcase
    end
    else if (s_axi_bvalid && s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // Registers hold only the low byte, so lane 0 must be enabled
  assign wrFlag = doWrite & wLane0 & (awAddr == TEC_A_FLAG);
  assign wrIen = doWrite & wLane0 & (awAddr == TEC_A_IEN);

  // Clock sources: sysclk/4 divider for timer 1 and free prescaler for timer 2
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      div4Cnt <= 2'h0;
    else
      div4Cnt <= div4Cnt + 2'h1;
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      pscCnt <= 7'h00;
    else
      pscCnt <= pscCnt + 7'h01;
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      xtalSync <= 3'h0;
    else
      xtalSync <= {xtalSync[1:0], lowFreqCrystal};
  end

  assign div4Tick = (div4Cnt == TEC_DIV4_LAST);
  // Only the second and third stages feed the edge detector, not the first
  assign xtalFall = xtalSync[2] & ~xtalSync[1];

  for (genvar i = 0; i < TEC_NUM; i++)
  begin : g_tmr
    localparam logic [7:0] CMASK = (i == 0) ? TEC_CTRL1_MASK : TEC_CTRL2_MASK;
    localparam logic [7:0] CTRL_ADDR = (i == 0) ? TEC_A_CTRL1 : TEC_A_CTRL2;
    localparam logic [7:0] TMR_ADDR = (i == 0) ? TEC_A_TMR1 : TEC_A_TMR2;
    tec_ctrl_s ctrl;
    tec_cap_e capState;
    logic [7:0] cnt;
    logic [7:0] pre;
    logic [2:0] pinSync;
    logic pinRise;
    logic pinFall;
    logic intTick;
    logic [6:0] pscMask;
    logic startEdge;
    logic stopEdge;
    logic tick;
    logic wrCtrl;
    logic wrTmr;
    logic capDone;

    assign wrCtrl = doWrite & wLane0 & (awAddr == CTRL_ADDR);
    assign wrTmr = doWrite & wLane0 & (awAddr == TMR_ADDR);

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
      if (!rst_b)
        pinSync <= 3'h0;
      else
        pinSync <= {pinSync[1:0], timerPin[i]};
    end

    assign pinRise = pinSync[1] & ~pinSync[2];
    assign pinFall = pinSync[2] & ~pinSync[1];

    // Mask of low prescaler bits; field 0 makes timer 2 tick every cycle
    assign pscMask = 7'(~(TEC_PSC_ALL << ctrl.psc));
    if (i == 0)
    begin : g_src1
      assign intTick = ctrl.clkSel ? xtalFall : div4Tick;
    end
    else
    begin : g_src2
      assign intTick = ((pscCnt | ~pscMask) == TEC_PSC_ALL);
    end

    assign startEdge = ctrl.edgeSel ? pinRise : pinFall;
    assign stopEdge = ctrl.edgeSel ? pinFall : pinRise;
    assign capDone = (capState == TEC_CAP_MEAS) & stopEdge;

    always_comb
    begin
      tick = 1'b0;
      case (ctrl.mode)
        TEC_MODE_EVENT:
          tick = ctrl.run & (ctrl.edgeSel ? pinFall : pinRise);
        TEC_MODE_TIMER:
          tick = ctrl.run & intTick;
        TEC_MODE_CAPTURE:
          tick = ctrl.run & (capState == TEC_CAP_MEAS) & ~stopEdge & intTick;
        default:
          tick = 1'b0;
      endcase
    end

    assign ovf[i] = tick & (cnt == TEC_FULL);

    // Control register; hardware clears run only at the end of a capture
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
      if (!rst_b)
        ctrl <= tec_ctrl_s'(TEC_CTRL_RST & CMASK);
      else if (wrCtrl)
        ctrl <= tec_ctrl_s'(wByte & CMASK);
      else if (capDone && ctrl.mode == TEC_MODE_CAPTURE)
        ctrl.run <= 1'b0;
    end

    // Setting run arms first; a start edge in the arming cycle is missed, not counted
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
      if (!rst_b)
        capState <= TEC_CAP_IDLE;
      else if (ctrl.mode != TEC_MODE_CAPTURE || !ctrl.run)
        capState <= TEC_CAP_IDLE;
      else
      begin
        case (capState)
          TEC_CAP_IDLE:
            capState <= TEC_CAP_ARMED;
          TEC_CAP_ARMED:
            if (startEdge)
              capState <= TEC_CAP_MEAS;
          TEC_CAP_MEAS:
            if (stopEdge)
              capState <= TEC_CAP_IDLE;
          default:
            capState <= TEC_CAP_IDLE;
        endcase
      end
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
      if (!rst_b)
        pre <= TEC_PRE_RST;
      else if (wrTmr)
        pre <= wByte;
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
      if (!rst_b)
        cnt <= TEC_PRE_RST;
      else if (wrTmr && !ctrl.run)
        cnt <= wByte;
      else if (ovf[i])
        cnt <= pre;
      else if (tick)
        cnt <= cnt + 8'h01;
    end

    assign ctrlRd[i] = ctrl & CMASK;
    assign cntRd[i] = cnt;
  end

  // Request flags: overflow sets regardless of enable, set wins over clear
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      ovfFlag <= '0;
    else if (wrFlag)
      ovfFlag <= (ovfFlag & ~wByte[TEC_NUM-1:0]) | ovf;
    else
      ovfFlag <= ovfFlag | ovf;
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      irqEnable <= '0;
    else if (wrIen)
      irqEnable <= wByte[TEC_NUM-1:0];
  end

  // Wake is independent of the enable, so it is taken from the raw overflow
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      timerIrq <= 1'b0;
    else
      timerIrq <= |(ovfFlag & irqEnable);
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      wakeReq <= 1'b0;
    else
      wakeReq <= |ovf;
  end

  always_comb
  begin
    rdByte = 8'h00;
    rdHit = 1'b1;
    case (s_axi_araddr)
      TEC_A_CTRL1: rdByte = ctrlRd[0];
      TEC_A_TMR1: rdByte = cntRd[0];
      TEC_A_CTRL2: rdByte = ctrlRd[1];
      TEC_A_TMR2: rdByte = cntRd[1];
      TEC_A_FLAG: rdByte = {6'h00, ovfFlag};
      TEC_A_IEN: rdByte = {6'h00, irqEnable};
      default: rdHit = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Data is caught at the take and holds while rready stays low
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= TEC_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rdata <= {24'h000000, rdByte};
      s_axi_rresp <= rdHit ? TEC_RESP_OKAY : TEC_RESP_SLVERR;
    end
  end

endmodule

// [tec_timer_pair_properties.sv]
`timescale 1ns/10ps
module tec_timer_pair_properties
  import tec_pkg::*;
(
  input wire logic sys_clk, // Clock
  input wire logic rst_b, // Reset
  input wire logic s_axi_awready, // AW ready
  input wire logic s_axi_wready, // W ready
  input wire logic s_axi_bvalid, // B valid
  input wire logic s_axi_arvalid, // AR valid
  input wire logic s_axi_arready, // AR ready
  input wire logic [TEC_ADDR_W-1:0] s_axi_araddr, // AR address
  input wire logic s_axi_rvalid, // R valid
  input wire logic s_axi_rready, // R ready
  input wire logic [31:0] s_axi_rdata // R data
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);
  sequence sRdTake;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence sRdAt(logic [TEC_ADDR_W-1:0] a);
    sRdTake ##0 (s_axi_araddr == a);
  endsequence
  a_read_answer: assert property (sRdTake |=> s_axi_rvalid)
    else $error("read not answered");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("second read accepted");
  a_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("second write accepted");
  a_ctrl1_low_zero: assert property (sRdAt(TEC_A_CTRL1) |=> s_axi_rdata[2:0] == 3'h0)
    else $error("control one low bits set");
  a_ctrl2_gap_zero: assert property (sRdAt(TEC_A_CTRL2) |=> !s_axi_rdata[5])
    else $error("control two bit five set");
  a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_reset_ready: assert property ($rose(rst_b) |-> s_axi_awready && s_axi_arready)
    else $error("bus not ready after reset");
endmodule
bind tec_timer_pair tec_timer_pair_properties props (.sys_clk, .rst_b, .s_axi_awready,
  .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata);

// [tec_pulse_src.sv]
`timescale 1ns/10ps
module tec_pulse_src
  import tec_pkg::*;
(
  input wire logic sys_clk, // Clock
  output logic [TEC_NUM-1:0] pin, // Timer input levels
  output logic xtal // Crystal, 400 ns period
);
  // Oscillator runs free, each edge 2 ns before a sys_clk rising edge
  initial
  begin
    pin = '0;
    xtal = 1'b0;
    #3;
    forever #200 xtal = ~xtal;
  end
  // Pin is only ever an input to the block; each level held whole clocks
  task automatic drive(input int i, input logic v, input int hold);
    @(posedge sys_clk);
    pin[i] <= v;
    repeat (hold) @(posedge sys_clk);
  endtask
endmodule

// [tec_timer_pair_tb.sv]
`timescale 1ns/10ps
module tec_timer_pair_tb
  import tec_pkg::*;
  ;
  logic sys_clk, rst_b, xtal, timerIrq, wakeReq, rdLate;
  logic [TEC_NUM-1:0] pin;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [TEC_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  int errCount, cmpCount, wakes;
  tec_timer_pair dut (.sys_clk, .rst_b, .timerPin(pin), .lowFreqCrystal(xtal), .s_axi_awvalid,
    .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .timerIrq, .wakeReq);
  tec_pulse_src src (.sys_clk, .pin, .xtal);
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
    if (wakeReq === 1'b1)
      wakes <= wakes + 1;
  task automatic endOfTest;
    $display("compares %0d mismatches %0d", cmpCount, errCount);
    if (errCount == 0 && cmpCount > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmpCount++;
    if (s !== e)
    begin
      errCount++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic guard(input int n);
    if (n >= 40)
    begin
      errCount++;
      endOfTest();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
      if (s_axi_awready === 1'b1)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1)
        s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1 && n < 40);
    guard(n);
    rr = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rdr(input logic [7:0] a);
    int n;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= !rdLate;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
      if (s_axi_arready === 1'b1)
        s_axi_arvalid <= 1'b0;
      // A late rready leaves the answer waiting, so the hold check has work
      if (n == 3)
        s_axi_rready <= 1'b1;
    end
    while (!(s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) && n < 40);
    guard(n);
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    rdr(a);
    chk(rd, e);
  endtask
  task automatic tRegs;
    rdchk(TEC_A_CTRL1, 8'h08);
    rdLate = 1'b1;
    rdchk(TEC_A_CTRL2, 8'h08);
    rdLate = 1'b0;
    wr(TEC_A_CTRL1, 8'hFF);
    rdchk(TEC_A_CTRL1, 8'hF8);
    wr(TEC_A_CTRL2, 8'hFF);
    rdchk(TEC_A_CTRL2, 8'hDF);
    wr(TEC_A_CTRL1, 8'h00);
    wr(TEC_A_CTRL2, 8'h00);
    rdchk(8'h18, 8'h00);
    chk(rr, TEC_RESP_SLVERR);
    wr(8'h18, 8'h55);
    chk(rr, TEC_RESP_SLVERR);
    $display("register test done");
  endtask
  task automatic tEvent(input int i);
    logic [7:0] ca, na, m;
    ca = (i == 1) ? TEC_A_CTRL2 : TEC_A_CTRL1;
    na = (i == 1) ? TEC_A_TMR2 : TEC_A_TMR1;
    m = (i == 1) ? TEC_CTRL2_MASK : TEC_CTRL1_MASK;
    wakes = 0;
    wr(na, 8'hFD);
    rdchk(na, 8'hFD);
    // Full prescale written on purpose, timer 1 masks it off: pin edges must still count one by one
    wr(ca, 8'h57);
    src.drive(i, 1'b1, 6);
    rdchk(na, 8'hFE);
    src.drive(i, 1'b0, 6);
    rdchk(na, 8'hFE);
    wr(ca, 8'h5F);
    src.drive(i, 1'b1, 6);
    rdchk(na, 8'hFE);
    src.drive(i, 1'b0, 6);
    rdchk(na, 8'hFF);
    src.drive(i, 1'b1, 6);
    src.drive(i, 1'b0, 6);
    rdchk(na, 8'hFD);
    rdchk(TEC_A_FLAG, 32'h1 << i);
    chk(timerIrq, 1'b0);
    chk(wakes, 1);
    rdchk(ca, 8'h5F & m);
    wr(TEC_A_IEN, 8'h03);
    repeat (2) @(posedge sys_clk);
    chk(timerIrq, 1'b1);
    wr(TEC_A_FLAG, 8'h03);
    repeat (2) @(posedge sys_clk);
    chk(timerIrq, 1'b0);
    wr(TEC_A_IEN, 8'h00);
    wr(na, 8'h10);
    rdchk(na, 8'hFD);
    wr(ca, 8'h10);
    src.drive(i, 1'b1, 6);
    src.drive(i, 1'b0, 6);
    rdchk(na, 8'hFD);
    wr(ca, 8'h00);
    $display("event test %0d done", i);
  endtask
  task automatic tRate(input logic [7:0] ca, na, v, input int div);
    logic [31:0] c;
    wr(na, 8'h00);
    wr(ca, v);
    repeat (20 * div) @(posedge sys_clk);
    wr(ca, v & 8'hEF);
    rdr(na);
    c = rd;
    // Bus latency adds a few ticks at fast rates only
    chk((c >= 19) && (c <= 22 + 5 / div), 1'b1);
    repeat (50) @(posedge sys_clk);
    rdchk(na, c);
    $display("rate test %h done", v);
  endtask
  task automatic tWrap;
    wr(TEC_A_TMR2, 8'hFE);
    wr(TEC_A_CTRL2, 8'h90);
    wr(TEC_A_CTRL2, 8'h80);
    rdr(TEC_A_TMR2);
    chk(rd >= 32'hFE, 1'b1);
    rdchk(TEC_A_FLAG, 8'h02);
    wr(TEC_A_FLAG, 8'h03);
    $display("wrap test done");
  endtask
  task automatic tCap(input logic e);
    logic [31:0] c;
    src.drive(1, ~e, 6);
    wr(TEC_A_TMR2, 8'h00);
    wr(TEC_A_CTRL2, {4'hD, e, 3'h0});
    repeat (20) @(posedge sys_clk);
    rdchk(TEC_A_TMR2, 8'h00);
    src.drive(1, e, 40);
    src.drive(1, ~e, 10);
    rdchk(TEC_A_CTRL2, {4'hC, e, 3'h0});
    rdr(TEC_A_TMR2);
    c = rd;
    chk((c >= 39) && (c <= 43), 1'b1);
    src.drive(1, e, 20);
    src.drive(1, ~e, 10);
    rdchk(TEC_A_TMR2, c);
    $display("capture test %0d done", e);
  endtask
  initial
  begin
    rst_b = 1'b0;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    errCount = 0;
    cmpCount = 0;
    rdLate = 1'b0;
    wakes = 0;
    repeat (5) @(posedge sys_clk);
    rst_b <= 1'b1;
    tRegs();
    for (int i = 0; i < 2; i++)
      tEvent(i);
    tRate(TEC_A_CTRL1, TEC_A_TMR1, 8'h90, 4);
    tRate(TEC_A_CTRL1, TEC_A_TMR1, 8'hB0, 40);
    for (int p = 0; p < 8; p++)
      tRate(TEC_A_CTRL2, TEC_A_TMR2, 8'h90 | p[7:0], 1 << p);
    tWrap();
    tCap(1'b0);
    tCap(1'b1);
    endOfTest();
  end
endmodule
